//--- logic/pbs_switch_channel.sv
// push-button channel in switching mode with wishbone configuration
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Function
// R1: rising edge command for object one, default on
// R2: falling edge command for object one, default off
// R3: rising edge command for object two
// R4: falling edge command for object two
// R5: toggle inverts stored value and sends it
// R6: cyclic modes none, on, off, both
// R7: both mode repeats whatever the value
// R8: object one cyclic base 1 s to 1.2 h; the code offers every base from 130 ms to 1.2 h
// R9: object two base up to 35 min, or off
// R10: shared factor 3..127, period base times factor; the code accepts every factor from 0 to 127
// R11: return reaction waits for startup delay
// R12: input-state reaction sends edge command for level
// R13: return reaction none, on or off
// R14: channel function; no function sends nothing
// R15: startup delay ignores inputs and sends nothing
// R16: edges count only after debounce time
// R17: rate limit: silent 17 s, capped per window
// R18: cyclic timer restarts on each transmission
// ------------------------------------------------------------------
module pbs_switch_channel #(
  parameter int TICK_CYCLES = pbs_pkg::TICK_CYCLES,
  parameter int RATE_WINDOW_TICKS = pbs_pkg::RATE_WINDOW_TICKS
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // push-button contact
  input wire logic button_i,
  // telegrams to the bus
  output logic tx_valid_o,
  output pbs_pkg::pbs_tel_t tx_tel_o,
  input wire logic tx_ready_i
);
  import pbs_pkg::*;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg, time_reg, limit_reg, rdata_reg;
  logic ack_reg;

  logic [31:0] lane_mask;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  wire bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire bus_wr = bus_req && wb_we_i;

  wire hit_ctrl = wb_adr_i == ADR_CTRL;
  wire hit_time = wb_adr_i == ADR_TIME;
  wire hit_limit = wb_adr_i == ADR_LIMIT;
  wire hit_status = wb_adr_i == ADR_STATUS;

  // byte enables widened to a bit mask
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign lane_mask[gb*8 +: 8] = {8{wb_sel_i[gb]}};
    end
  endgenerate

  wire [31:0] ctrl_wr = (ctrl_reg & ~lane_mask) | (wb_dat_i & lane_mask);
  wire [31:0] time_wr = (time_reg & ~lane_mask) | (wb_dat_i & lane_mask);
  wire [31:0] limit_wr = (limit_reg & ~lane_mask) | (wb_dat_i & lane_mask);

  // unmapped addresses read zero and ignore writes
  assign rd_mux = hit_ctrl ? ctrl_reg :
                  hit_time ? time_reg :
                  hit_limit ? limit_reg :
                  hit_status ? status_word : 32'h0000_0000;

  // one wait state: ack lands the cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      time_reg <= TIME_RST;
      limit_reg <= LIMIT_RST;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= bus_req;
      rdata_reg <= bus_req ? rd_mux : 32'h0000_0000;
      if (bus_wr && hit_ctrl) ctrl_reg <= ctrl_wr;
      if (bus_wr && hit_time) time_reg <= time_wr;
      if (bus_wr && hit_limit) limit_reg <= limit_wr;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  pbs_cmd_t rise_cmd [2];
  pbs_cmd_t fall_cmd [2];

  wire pbs_func_t func = pbs_func_t'(ctrl_reg[F_FUNC +: 3]);
  wire pbs_cyc_t cyc_mode = pbs_cyc_t'(ctrl_reg[F_CYC +: 2]);
  wire pbs_ret_t ret_mode = pbs_ret_t'(ctrl_reg[F_RET +: 2]);
  wire rate_en = ctrl_reg[F_RATE_EN];

  wire [3:0] base1 = time_reg[F_BASE1 +: 4];
  wire [3:0] base2 = time_reg[F_BASE2 +: 4];
  wire [6:0] cyc_factor = time_reg[F_CFACT +: 7];
  wire [3:0] delay_base = time_reg[F_DBASE +: 4];
  wire [6:0] delay_factor = time_reg[F_DFACT +: 7];

  wire [7:0] deb_factor = limit_reg[F_DEB +: 8];
  wire [6:0] rate_max = limit_reg[F_RMAX +: 7];

  assign rise_cmd[0] = pbs_cmd_t'(ctrl_reg[F_RISE1 +: 2]); // R1
  assign fall_cmd[0] = pbs_cmd_t'(ctrl_reg[F_FALL1 +: 2]); // R2
  assign rise_cmd[1] = pbs_cmd_t'(ctrl_reg[F_RISE2 +: 2]); // R3
  assign fall_cmd[1] = pbs_cmd_t'(ctrl_reg[F_FALL2 +: 2]); // R4

  // only the switching function produces telegrams here
  wire switching = func == FN_SWITCH; // R14

  // ----------------------------------------------------------------
  // 0.5 ms tick
  // ----------------------------------------------------------------
  logic [17:0] pre_reg;

  wire tick = ce_i && (pre_reg == 18'(TICK_CYCLES - 1));

  // prescaler shared by every timer of the channel
  always_ff @(posedge clk_i) begin
    if (rst_i) pre_reg <= 18'h00000;
    else if (ce_i) pre_reg <= tick ? 18'h00000 : pre_reg + 18'h00001;
  end

  // ----------------------------------------------------------------
  // input contact
  // ----------------------------------------------------------------
  logic in_level, in_rise, in_fall;

  pbs_debounce u_deb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick_i(tick),
    .factor_i(deb_factor),
    .pin_i(button_i),
    .level_o(in_level),
    .rise_o(in_rise),
    .fall_o(in_fall)
  );

  // ----------------------------------------------------------------
  // startup delay and return reaction
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_DELAY, ST_RETURN, ST_RUN} pbs_state_t;

  pbs_state_t state_reg, state_next;
  logic [TW-1:0] dly_reg;

  wire [37:0] dly_prod = pbs_base_ticks(delay_base) * delay_factor;
  wire [TW-1:0] dly_ticks = dly_prod[TW-1:0];

  wire dly_done = dly_reg >= dly_ticks;

  // delay base times factor, counted once after reset
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_DELAY: if (dly_done) state_next = ST_RETURN; // R15
      ST_RETURN: state_next = ST_RUN; // R11
      ST_RUN: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_DELAY;
      dly_reg <= '0;
    end else if (ce_i) begin
      state_reg <= state_next;
      if (state_reg == ST_DELAY && tick && !dly_done) dly_reg <= dly_reg + 31'd1;
    end
  end

  wire running = state_reg == ST_RUN;
  wire do_return = ce_i && state_reg == ST_RETURN && switching;

  // ----------------------------------------------------------------
  // command evaluation per object
  // ----------------------------------------------------------------
  logic [1:0] val_reg, pend_reg, set_ev, new_val, cyc_fire, sent, cyc_en;
  pbs_cmd_t cmd_sel [2];
  logic [TW-1:0] cyc_period [2];

  wire [37:0] per1_prod = pbs_base_ticks(base1) * cyc_factor;
  wire [37:0] per2_prod = pbs_base_ticks(base2) * cyc_factor;

  wire edge_ok = ce_i && running && switching; // R15 R14

  assign cyc_period[0] = per1_prod[TW-1:0]; // R8 R10
  assign cyc_period[1] = per2_prod[TW-1:0]; // R9 R10

  genvar go;
  generate
    for (go = 0; go < 2; go++) begin : g_obj
      // return reaction picks the command like an edge would
      always_comb begin
        cmd_sel[go] = CMD_NONE;
        if (do_return) begin
          unique case (ret_mode)
            RET_NONE: cmd_sel[go] = CMD_NONE; // R13
            RET_ON: cmd_sel[go] = CMD_ON; // R13
            RET_OFF: cmd_sel[go] = CMD_OFF; // R13
            RET_INPUT: cmd_sel[go] = in_level ? rise_cmd[go] : fall_cmd[go]; // R12
          endcase
        end else if (edge_ok && in_rise) begin
          cmd_sel[go] = rise_cmd[go]; // R1 R3
        end else if (edge_ok && in_fall) begin
          cmd_sel[go] = fall_cmd[go]; // R2 R4
        end
      end

      // toggle inverts the stored object value
      always_comb begin
        new_val[go] = val_reg[go];
        unique case (cmd_sel[go])
          CMD_NONE: new_val[go] = val_reg[go];
          CMD_ON: new_val[go] = 1'b1;
          CMD_OFF: new_val[go] = 1'b0;
          CMD_TOGGLE: new_val[go] = ~val_reg[go]; // R5
        endcase
      end

      // cyclic mode decides by the current object value
      assign cyc_en[go] = running && switching &&
                          ((cyc_mode == CYC_BOTH) || // R7
                           (cyc_mode == CYC_ON && val_reg[go]) || // R6
                           (cyc_mode == CYC_OFF && !val_reg[go])) && // R6
                          !(go == 1 && base2 == BASE2_OFF); // R9

      pbs_cyc_timer #(
        .TW(TW)
      ) u_cyc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(tick),
        .enable_i(cyc_en[go]),
        .restart_i(sent[go]), // R18
        .period_i(cyc_period[go]),
        .fire_o(cyc_fire[go])
      );

      assign set_ev[go] = (cmd_sel[go] != CMD_NONE) || cyc_fire[go];
    end
  endgenerate

  // ----------------------------------------------------------------
  // telegram rate limit
  // ----------------------------------------------------------------
  logic [TW-1:0] win_reg;
  logic [6:0] win_cnt_reg;
  logic first_win_reg;

  wire win_end = tick && (win_reg == 31'(RATE_WINDOW_TICKS - 1));
  wire rate_block = rate_en && (first_win_reg || win_cnt_reg >= rate_max); // R17

  // 17 s windows; the first one after reset stays silent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_reg <= '0;
      win_cnt_reg <= 7'h00;
      first_win_reg <= 1'b1;
    end else if (ce_i) begin
      if (win_end) win_reg <= '0;
      else if (tick) win_reg <= win_reg + 31'd1;
      if (win_end) first_win_reg <= 1'b0; // R17
      if (win_end) win_cnt_reg <= 7'h00;
      else if (|sent && win_cnt_reg != 7'h7f) win_cnt_reg <= win_cnt_reg + 7'h01; // R17
    end
  end

  // ----------------------------------------------------------------
  // pending telegrams and output stage
  // ----------------------------------------------------------------
  logic out_valid_reg;
  pbs_tel_t out_reg;

  wire load = ce_i && (|pend_reg) && !rate_block && running && switching &&
              (!out_valid_reg || tx_ready_i); // R15 R17 R14
  wire load_obj = !pend_reg[0]; // first object has priority

  assign sent[0] = load && !load_obj;
  assign sent[1] = load && load_obj;

  // a new event wins over the clear of the same pending bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      val_reg <= 2'b00;
      pend_reg <= 2'b00;
    end else if (ce_i) begin
      val_reg <= new_val; // R5
      pend_reg <= (pend_reg & ~sent) | set_ev;
    end
  end

  // held stable until the bus takes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_reg <= 1'b0;
      out_reg <= '0;
    end else if (ce_i) begin
      if (load) begin
        out_valid_reg <= 1'b1;
        out_reg.obj <= load_obj;
        out_reg.value <= val_reg[load_obj];
      end else if (tx_ready_i) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  assign tx_valid_o = out_valid_reg;
  assign tx_tel_o = out_reg;

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  assign status_word = {25'h0000000, rate_block, pend_reg, !running, in_level, val_reg};

endmodule : pbs_switch_channel

//--- logic/pbs_pkg.sv
// shared types, register map and timing constants of the push-button switching channel
package pbs_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 500; // debounce base time of 0.5 ms
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US; // 125000, a top parameter
  localparam int RATE_WINDOW_S = 17;
  localparam int RATE_WINDOW_TICKS = RATE_WINDOW_S * 1000000 / TICK_US;
  localparam int TW = 31; // width of tick counts

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CMD_NONE, CMD_ON, CMD_OFF, CMD_TOGGLE} pbs_cmd_t;
  typedef enum logic [1:0] {CYC_NONE, CYC_ON, CYC_OFF, CYC_BOTH} pbs_cyc_t;
  typedef enum logic [1:0] {RET_NONE, RET_ON, RET_OFF, RET_INPUT} pbs_ret_t;
  typedef enum logic [2:0] {FN_NONE, FN_SWITCH, FN_DIM, FN_BLIND, FN_VALUE} pbs_func_t;

  // telegram to the installation bus
  typedef struct packed {
    logic obj; // 0 first switching object, 1 second
    logic value; // 1 on, 0 off
  } pbs_tel_t;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_TIME = 4'h4;
  localparam logic [3:0] ADR_LIMIT = 4'h8;
  localparam logic [3:0] ADR_STATUS = 4'hc;
  localparam logic [31:0] CTRL_RST = 32'h0000_0049;
  localparam logic [31:0] TIME_RST = 32'h0113_3cf3;
  localparam logic [31:0] LIMIT_RST = 32'h0000_1e3c;

  // control fields
  localparam int F_FUNC = 0;
  localparam int F_RISE1 = 3;
  localparam int F_FALL1 = 5;
  localparam int F_RISE2 = 7;
  localparam int F_FALL2 = 9;
  localparam int F_CYC = 11;
  localparam int F_RET = 13;
  localparam int F_RATE_EN = 15;
  // time fields
  localparam int F_BASE1 = 0;
  localparam int F_BASE2 = 4;
  localparam int F_CFACT = 8;
  localparam int F_DBASE = 16;
  localparam int F_DFACT = 20;
  // limit fields
  localparam int F_DEB = 0;
  localparam int F_RMAX = 8;
  // base index that switches off cyclic sending of the second object
  localparam logic [3:0] BASE2_OFF = 4'hf;

  // time bases in 0.5 ms ticks: 130 ms .. 1.2 h
  function automatic logic [TW-1:0] pbs_base_ticks(input logic [3:0] idx);
    logic [TW-1:0] t;
    t = 31'd0;
    unique case (idx)
      4'h0: t = 31'd260;
      4'h1: t = 31'd520;
      4'h2: t = 31'd1040;
      4'h3: t = 31'd2000;
      4'h4: t = 31'd4200;
      4'h5: t = 31'd8400;
      4'h6: t = 31'd16800;
      4'h7: t = 31'd34000;
      4'h8: t = 31'd68000;
      4'h9: t = 31'd132000;
      4'ha: t = 31'd264000;
      4'hb: t = 31'd540000;
      4'hc: t = 31'd1080000;
      4'hd: t = 31'd2160000;
      4'he: t = 31'd4200000;
      4'hf: t = 31'd8640000;
    endcase
    return t;
  endfunction : pbs_base_ticks

endpackage : pbs_pkg

//--- logic/pbs_debounce.sv
// three-stage input synchroniser with tick-based debounce and edge pulses
`timescale 1ns/10ps
module pbs_debounce (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // time base and setting
  input wire logic tick_i,
  input wire logic [7:0] factor_i,
  // raw contact and results
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  import pbs_pkg::*;

  logic s1_reg, s2_reg, s3_reg, stable_reg, level_reg;
  logic [8:0] cnt_reg;
  wire differs = stable_reg != level_reg;
  wire accept = differs && (cnt_reg > 9'(factor_i) || factor_i == 8'h00);

  // synchroniser: stage 1 feeds only stage 2
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      stable_reg <= 1'b0;
    end else if (ce_i) begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) stable_reg <= s2_reg;
    end
  end

  // level must hold the debounce time before the edge counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 9'h000;
      level_reg <= 1'b0;
    end else if (ce_i) begin
      if (!differs || accept) cnt_reg <= 9'h000;
      else if (tick_i) cnt_reg <= cnt_reg + 9'h001;
      if (accept) level_reg <= stable_reg; // R16
    end
  end

  assign level_o = level_reg;
  assign rise_o = ce_i && accept && stable_reg;
  assign fall_o = ce_i && accept && !stable_reg;

endmodule : pbs_debounce

//--- logic/pbs_cyc_timer.sv
// cyclic retransmission timer, restarted by each transmission
`timescale 1ns/10ps
module pbs_cyc_timer #(
  parameter int TW = 31
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic restart_i,
  input wire logic [TW-1:0] period_i,
  // period elapsed
  output logic fire_o
);
  import pbs_pkg::*;

  logic [TW-1:0] cnt_reg;
  wire due = enable_i && tick_i && (cnt_reg >= period_i - 31'd1);

  // counts from the latest transmission; held at zero while disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (ce_i) begin
      if (!enable_i || restart_i || due) cnt_reg <= '0; // R18
      else if (tick_i) cnt_reg <= cnt_reg + 31'd1;
    end
  end

  assign fire_o = ce_i && due && !restart_i;

endmodule : pbs_cyc_timer

//--- test/pbs_switch_channel_assertions.sv
// assertion checker of the push-button switching channel, bound to its top
`timescale 1ns/10ps
module pbs_channel_checker #(
  parameter int TICK_CYCLES = 10,
  parameter int RATE_WINDOW_TICKS = 20
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // contact and telegrams
  input wire logic button_i,
  input wire logic tx_valid_o,
  input wire pbs_pkg::pbs_tel_t tx_tel_o,
  input wire logic tx_ready_i
);
  import pbs_pkg::*;
  logic [31:0] ctrl_s, time_s, limit_s, exp_q;
  logic exp_v;
  int cyc_n, tick_n, nf_n;
  // request decode
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  wire wr = take && wb_we_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = d[8*i +: 8];
    return o;
  endfunction : merge

  // shadow copy of the writable registers, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_s <= CTRL_RST;
      time_s <= TIME_RST;
      limit_s <= LIMIT_RST;
    end else begin
      if (wr && wb_adr_i == ADR_CTRL) ctrl_s <= merge(ctrl_s, wb_dat_i, wb_sel_i);
      if (wr && wb_adr_i == ADR_TIME) time_s <= merge(time_s, wb_dat_i, wb_sel_i);
      if (wr && wb_adr_i == ADR_LIMIT) limit_s <= merge(limit_s, wb_dat_i, wb_sel_i);
    end
  end
  // expected read word, ticks since reset, cycles without switching function
  always_ff @(posedge clk_i) begin
    exp_v <= !rst_i && take && !wb_we_i && (wb_adr_i inside {ADR_CTRL, ADR_TIME, ADR_LIMIT});
    exp_q <= (wb_adr_i == ADR_CTRL) ? ctrl_s : (wb_adr_i == ADR_TIME) ? time_s : limit_s;
    cyc_n <= (rst_i || cyc_n == TICK_CYCLES - 1) ? 0 : cyc_n + 1;
    tick_n <= rst_i ? 0 : tick_n + int'(cyc_n == TICK_CYCLES - 1);
    nf_n <= (rst_i || ctrl_s[2:0] == FN_SWITCH) ? 0 : nf_n + 1;
  end

  ack_next_a: assert property (take |=> wb_ack_o)
    else $error("no acknowledge one cycle after a request");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(take))
    else $error("acknowledge without a request");
  read_data_a: assert property (wb_ack_o && exp_v |-> wb_dat_o == exp_q)
    else $error("read data differs from register contents");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside acknowledge");
  tel_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_tel_o))
    else $error("telegram changed before the bus took it");
  rst_quiet_a: assert property (disable iff (1'b0)
    $fell(rst_i) |-> !wb_ack_o && !tx_valid_o && tx_tel_o == '0)
    else $error("outputs not quiet after reset");
  // margin of two ticks covers tick phase; every delay base is at least 260 ticks
  startup_mute_a: assert property (
    tick_n + 2 < 260 * int'(time_s[26:20]) |-> !tx_valid_o)
    else $error("telegram during startup delay");
  rate_mute_a: assert property (
    ctrl_s[15] && tick_n + 2 < RATE_WINDOW_TICKS |-> !tx_valid_o)
    else $error("telegram in first limited window");
  func_mute_a: assert property (nf_n > 4 |-> !tx_valid_o)
    else $error("telegram without switching function");
endmodule : pbs_channel_checker

bind pbs_switch_channel pbs_channel_checker #(
  .TICK_CYCLES(TICK_CYCLES), .RATE_WINDOW_TICKS(RATE_WINDOW_TICKS)
) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .button_i(button_i),
  .tx_valid_o(tx_valid_o), .tx_tel_o(tx_tel_o), .tx_ready_i(tx_ready_i)
);

//--- test/pbs_bus_model.sv
// installation bus model that takes telegrams promptly or slowly
`timescale 1ns/10ps
module pbs_bus_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // telegram handshake
  input wire logic tx_valid_i,
  input wire pbs_pkg::pbs_tel_t tx_tel_i,
  output logic tx_ready_o,
  // stall setting and delivered telegram
  input wire logic slow_i,
  output logic got_o,
  output pbs_pkg::pbs_tel_t tel_o
);
  import pbs_pkg::*;
  logic [1:0] wait_reg;
  // slow mode keeps a telegram waiting three cycles to stress the hold
  assign tx_ready_o = !slow_i || wait_reg == 2'h0;
  always_ff @(posedge clk_i) begin
    got_o <= !rst_i && tx_valid_i && tx_ready_o;
    if (tx_valid_i && tx_ready_o) tel_o <= tx_tel_i;
    if (rst_i || (tx_valid_i && tx_ready_o)) wait_reg <= 2'h3;
    else if (tx_valid_i && wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
  end
endmodule : pbs_bus_model

//--- test/tb_pbs_switch_channel.sv
// self-checking testbench of the push-button switching channel
`timescale 1ns/10ps
module tb_pbs_switch_channel;
  import pbs_pkg::*;
  localparam logic [31:0] TIME_V = 32'h0030_03f0; // delay and obj1 period 780 ticks
  localparam logic [31:0] LIMIT_V = 32'h0000_1e02; // debounce 2 ticks
  logic clk_i, rst_i, ce_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic button, slow, tx_valid, tx_ready, got, v1, v2;
  logic [3:0] wb_adr, wb_sel;
  logic [31:0] wb_dat, wb_q, rd;
  pbs_tel_t tx_tel, tel;
  pbs_tel_t tq[$];
  int num_errors = 0;
  int total_checks = 0;

  pbs_switch_channel #(.TICK_CYCLES(10), .RATE_WINDOW_TICKS(1000)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q),
    .wb_ack_o(wb_ack), .button_i(button), .tx_valid_o(tx_valid), .tx_tel_o(tx_tel),
    .tx_ready_i(tx_ready)
  );
  pbs_bus_model bus_u (
    .clk_i(clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid), .tx_tel_i(tx_tel),
    .tx_ready_o(tx_ready), .slow_i(slow), .got_o(got), .tel_o(tel)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // every telegram the bus accepted, in order
  always @(posedge clk_i) begin
    if (got === 1'b1) tq.push_back(tel);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one classic cycle; waits for ack however long it takes
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat <= d;
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    rd = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic press(input logic lvl);
    @(posedge clk_i);
    button <= lvl;
  endtask : press

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    tq.delete();
    v1 = 1'b0;
    v2 = 1'b0;
  endtask : do_reset

  task automatic cfg();
    wb(1'b1, ADR_TIME, TIME_V);
    wb(1'b1, ADR_LIMIT, LIMIT_V);
  endtask : cfg

  task automatic expect_tel(input string what, input logic [1:0] exp, input int lim);
    int n;
    n = 0;
    while (tq.size() == 0 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (tq.size() == 0) check(what, 32'hffff_ffff, {30'h0, exp});
    else check(what, {30'h0, tq.pop_front()}, {30'h0, exp});
  endtask : expect_tel

  task automatic expect_none(input string what, input int lim);
    repeat (lim) @(posedge clk_i);
    check(what, tq.size(), 32'h0);
  endtask : expect_none

  function automatic logic nxt(input int c, input logic v);
    return c == 1 ? 1'b1 : c == 2 ? 1'b0 : c == 3 ? !v : v;
  endfunction : nxt

  task automatic t_regs();
    wb(1'b0, ADR_CTRL, 32'h0);
    check("rise1 default", rd[4:3], CMD_ON);
    check("fall1 default", rd[6:5], CMD_OFF);
    wb(1'b0, ADR_TIME, 32'h0);
    check("base1 default", rd[3:0], 32'h3);
    check("base2 default", rd[7:4], BASE2_OFF);
    check("factor default", rd[14:8], 32'd60);
    wb(1'b0, ADR_LIMIT, 32'h0);
    check("debounce default", rd[7:0], 32'd60);
    cfg();
    wb(1'b0, ADR_TIME, 32'h0);
    check("time written", rd, TIME_V);
    $display("test registers done");
  endtask : t_regs

  task automatic t_startup();
    press(1'b1);
    expect_none("edge in delay", 200);
    repeat (8000) @(posedge clk_i);
    expect_none("no return reaction", 1);
    press(1'b0);
    expect_none("debounce hold", 20);
    expect_tel("fall obj1", 2'b00, 200);
    $display("test startup done");
  endtask : t_startup

  task automatic t_cmds();
    for (int c = 0; c < 4; c++) begin
      slow <= c[0];
      wb(1'b1, ADR_CTRL, 32'h1 | (c << F_RISE1) | (c << F_FALL2));
      press(1'b1);
      v1 = nxt(c, v1);
      if (c == 0) expect_none("rise none", 200);
      else expect_tel("rise obj1", {1'b0, v1}, 200);
      press(1'b0);
      v2 = nxt(c, v2);
      if (c == 0) expect_none("fall none", 200);
      else expect_tel("fall obj2", {1'b1, v2}, 200);
    end
    $display("test commands done");
  endtask : t_cmds

  task automatic t_func();
    for (int f = 0; f < 5; f++) begin
      if (f == 1) continue;
      wb(1'b1, ADR_CTRL, f | 32'h8);
      press(1'b1);
      expect_none("other function rise", 200);
      press(1'b0);
      expect_none("other function fall", 200);
    end
    $display("test functions done");
  endtask : t_func

  task automatic t_cyclic();
    wb(1'b1, ADR_CTRL, 32'h1 | (32'h3 << F_CYC));
    expect_tel("cyclic first", {1'b0, v1}, 8200);
    expect_none("cyclic early", 7600);
    expect_tel("cyclic again", {1'b0, v1}, 600);
    wb(1'b1, ADR_CTRL, 32'h1 | ((v1 ? 32'h2 : 32'h1) << F_CYC));
    expect_none("cyclic other value", 9000);
    $display("test cyclic done");
  endtask : t_cyclic

  task automatic t_return();
    press(1'b1);
    for (int r = 1; r < 4; r++) begin
      do_reset();
      cfg();
      wb(1'b1, ADR_CTRL, 32'h8109 | (r << F_RET));
      expect_none("return in delay", 9500);
      expect_tel("return obj1", {1'b0, r != 2}, 1500);
      expect_tel("return obj2", {1'b1, r == 1}, 200);
    end
    $display("test return done");
  endtask : t_return

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  // watchdog, above the roughly 65000 cycles the tests need
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 4'h0;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    button = 1'b0;
    slow = 1'b0;
    do_reset();
    t_regs();
    t_startup();
    t_cmds();
    t_func();
    t_cyclic();
    t_return();
    wrap_up();
  end
endmodule : tb_pbs_switch_channel
